// *** src/asc_ctrl.sv ***
// Purpose: clocked controller driving an asynchronous 1M x 16 static memory
// Assumes: pins sampled synchronously; one request at a time
// Notes:   write terminated by write strobe rising; chip select rises on the same edge
//          every interval is a whole number of core cycles, so each access
//          runs 15 ns (write) to 25 ns (read) longer than the memory needs; requests with no lane
//          selected are dropped without an answer
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
(
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_req,
  input  wire logic                          i_req_write,
  input  wire logic [asc_pkg::ADDR_W-1:0]    i_req_addr,
  input  wire logic [asc_pkg::DATA_W-1:0]    i_req_wdata,
  input  wire logic [1:0]                    i_req_be,
  output logic                               o_ready,
  output logic                               o_done,
  output logic [asc_pkg::DATA_W-1:0]         o_rdata,
  output logic [asc_pkg::ADDR_W-1:0]         o_mem_addr,
  output logic                               o_chip_select_n,
  output logic                               o_chip_select_hi,
  output logic                               o_write_n,
  output logic                               o_gate_n,
  output logic                               o_upper_byte_sel_n,
  output logic                               o_lower_byte_sel_n,
  input  wire logic [asc_pkg::DATA_W-1:0]    i_mem_data,
  output logic [asc_pkg::DATA_W-1:0]         o_mem_data,
  output logic                               o_mem_data_oe_n
);
  import asc_pkg::*;

  asc_state_t state;
  logic       load;
  logic [3:0] load_val;
  logic       tmr_done;
  logic       acc_end;
  logic       turn_end;
  logic [1:0] lane_sel_n;

  // ****************************************
  // interval timer
  // ****************************************
  // one shared timer: accesses never overlap, so one counter serves every phase
  asc_delay u_delay (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_load     (load),
    .i_value    (load_val),
    .o_done     (tmr_done)
  );

  wire logic take = (state == ASC_IDLE) && i_req && (i_req_be != 2'b00);

  // an access ends on the first edge the timer reads zero; that same edge
  // reloads it for the release gap, so no cycle is lost in between
  assign acc_end  = ((state == ASC_READ) || (state == ASC_WRITE)) && tmr_done;
  assign turn_end = (state == ASC_TURN) && tmr_done;

  always_comb
  begin
    load     = 1'b0;
    load_val = CNT_RST;
    if (take)
    begin
      load     = 1'b1;
      load_val = i_req_write ? WR_CYC : RD_CYC;
    end
    else if (acc_end)
    begin
      load     = 1'b1;
      load_val = REL_CYC;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      state <= ASC_IDLE;
    else
      case (state)
        ASC_IDLE:
          if (take)
            state <= i_req_write ? ASC_WRITE : ASC_READ;
        ASC_READ:
          if (acc_end)
            state <= ASC_TURN;
        ASC_WRITE:
          if (acc_end)
            state <= ASC_TURN;
        ASC_TURN:
          if (turn_end)
            state <= ASC_IDLE;
        default:
          state <= ASC_IDLE;
      endcase
  end

  // ****************************************
  // memory pins
  // ****************************************
  // address and write data latched on take and held through turnaround
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_mem_addr         <= '0;
      o_mem_data         <= '0;
    end
    else if (take)
    begin
      o_mem_addr         <= i_req_addr;
      o_mem_data         <= i_req_wdata;
    end
  end

  // ****************************************
  // byte lanes
  // ****************************************
  // a lane select moves only on take, together with the chip select,
  // so it never toggles while the memory is disabled
  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    always_ff @(posedge i_core_clk)
    begin
      if (i_rst)
        lane_sel_n[g] <= 1'b1;
      else if (take)
        lane_sel_n[g] <= !i_req_be[g];
    end
  end

  assign o_upper_byte_sel_n = lane_sel_n[1];
  assign o_lower_byte_sel_n = lane_sel_n[0];

  // byte selects only change together with chip select, never while disabled
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_chip_select_n  <= 1'b1;
      o_chip_select_hi <= 1'b0;
      o_write_n        <= 1'b1;
      o_gate_n         <= 1'b1;
      o_mem_data_oe_n  <= 1'b1;
    end
    else if (take)
    begin
      o_chip_select_n  <= 1'b0;
      o_chip_select_hi <= 1'b1;
      o_write_n        <= !i_req_write;
      o_gate_n         <= i_req_write;
      o_mem_data_oe_n  <= !i_req_write;
    end
    else if (acc_end)
    begin
      // write ends on strobe rise; data and address held until the next take
      o_write_n        <= 1'b1;
      o_gate_n         <= 1'b1;
      o_chip_select_n  <= 1'b1;
      o_chip_select_hi <= 1'b0;
      o_mem_data_oe_n  <= 1'b1;
    end
  end

  // ****************************************
  // request side
  // ****************************************
  // capture two cycles past the longest access limit, never on the limit itself
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_rdata <= '0;
    else if (state == ASC_READ && tmr_done)
      o_rdata <= i_mem_data;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_done <= 1'b0;
    else
      o_done <= acc_end;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_ready <= 1'b0;
    else
      // ready only once the release gap is over, never inside it
      o_ready <= turn_end || ((state == ASC_IDLE) && !take);
  end
endmodule : asc_ctrl

// *** src/asc_pkg.sv ***
// Purpose: constants for the asynchronous static memory controller
// Assumes: 100 MHz core clock, 20-bit word address, 16-bit data
// Notes:   times in ns, cycle counts derived by rounding up
package asc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned DATA_W        = 16;

  // ****************************************
  // interface timing
  // ****************************************
  localparam int unsigned ADDRESS_ACCESS_DELAY_NS  = 45;
  localparam int unsigned SELECT_ACCESS_DELAY_NS   = 45;
  localparam int unsigned GATE_ACCESS_DELAY_NS     = 22;
  localparam int unsigned BYTE_SEL_ACCESS_DELAY_NS = 45;
  localparam int unsigned DESELECT_RELEASE_NS      = 18;
  localparam int unsigned SELECT_TO_WRITE_END_NS   = 35;
  localparam int unsigned ADDRESS_TO_WRITE_END_NS  = 35;
  localparam int unsigned BYTE_SEL_TO_WRITE_END_NS = 35;
  localparam int unsigned WRITE_DATA_LEAD_NS       = 25;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int unsigned RD_ACC_NS = (ADDRESS_ACCESS_DELAY_NS > SELECT_ACCESS_DELAY_NS)
                                      ? ADDRESS_ACCESS_DELAY_NS : SELECT_ACCESS_DELAY_NS;
  localparam int unsigned WR_WIN_NS = SELECT_TO_WRITE_END_NS;
  // sample two cycles after the access delay so data is settled at the edge
  localparam logic [3:0] RD_CYC  = 4'(ns_to_cyc(RD_ACC_NS) + 1);
  localparam logic [3:0] WR_CYC  = 4'(ns_to_cyc(WR_WIN_NS));
  localparam logic [3:0] REL_CYC = 4'(ns_to_cyc(DESELECT_RELEASE_NS));
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef enum logic [3:0] {
    ASC_IDLE  = 4'b0001,
    ASC_READ  = 4'b0010,
    ASC_WRITE = 4'b0100,
    ASC_TURN  = 4'b1000
  } asc_state_t;
endpackage : asc_pkg

// *** src/asc_delay.sv ***
// Purpose: down counter that flags when a programmed cycle count has run out
// Assumes: load and count are synchronous to the core clock
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module asc_delay
  import asc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [3:0] i_value,
  output logic            o_done
);
  logic [3:0] cnt;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      cnt <= CNT_RST;
    else if (i_load)
      cnt <= i_value;
    else if (cnt != CNT_RST)
      cnt <= cnt - 4'h1;
  end

  // no load term here: the controller's load decode reads o_done, so one
  // would close a combinational loop through this port
  assign o_done = (cnt == CNT_RST);
endmodule : asc_delay

// *** tb/asc_mem_model.sv ***
// Purpose: behavioural static memory facing the controller
// Assumes: pins driven by asc_ctrl, write data taken straight from its register
// Notes:   lanes not driven show the inverse word, never a stale copy
`timescale 1ns/1ps
module asc_mem_model
  import asc_pkg::*;
(
  input  wire logic [asc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_cs_hi,
  input  wire logic                       i_we_n,
  input  wire logic                       i_oe_n,
  input  wire logic                       i_ub_n,
  input  wire logic                       i_lb_n,
  input  wire logic [asc_pkg::DATA_W-1:0] i_data,
  output logic      [asc_pkg::DATA_W-1:0] o_data
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] lane;
  wire sel = !i_cs_n && i_cs_hi && !(i_ub_n && i_lb_n);
  wire wr  = sel && !i_we_n;
  assign w = mem[i_addr];
  assign lane = {{8{!i_ub_n}}, {8{!i_lb_n}}} & {16{sel && i_we_n && !i_oe_n}};
  // 15 ns sits above both hold minimums and below every access and release limit
  assign #15 o_data = (w & lane) | (~w & ~lane);
  always @(negedge wr)
  begin
    if (!i_ub_n) mem[i_addr][15:8] = i_data[15:8];
    if (!i_lb_n) mem[i_addr][7:0] = i_data[7:0];
  end
endmodule : asc_mem_model

// *** tb/asc_ctrl_asserts.sv ***
// Purpose: pin timing checks on the controller
// Assumes: one clock, i_rst synchronous active high
// Notes:   cycle figures follow the controller's timer at 10 ns
`timescale 1ns/1ps
module asc_ctrl_asserts
  import asc_pkg::*;
(
  input wire logic                       i_core_clk,
  input wire logic                       i_rst,
  input wire logic                       o_ready,
  input wire logic                       o_done,
  input wire logic [asc_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic                       o_chip_select_n,
  input wire logic                       o_chip_select_hi,
  input wire logic                       o_write_n,
  input wire logic                       o_gate_n,
  input wire logic                       o_upper_byte_sel_n,
  input wire logic                       o_lower_byte_sel_n,
  input wire logic [asc_pkg::DATA_W-1:0] o_mem_data,
  input wire logic                       o_mem_data_oe_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr_hold;
    (!o_write_n && !o_chip_select_n && $stable(o_mem_addr)
      && $stable({o_upper_byte_sel_n, o_lower_byte_sel_n}))[*4] ##1 o_write_n;
  endsequence
  AST_WR_HOLD: assert property ($fell(o_write_n) |=> s_wr_hold)
    else $error("write window too short");
  AST_WR_START: assert property ($fell(o_write_n) |-> o_chip_select_hi && !o_mem_data_oe_n
    && !(o_upper_byte_sel_n && o_lower_byte_sel_n)) else $error("write start bad");
  AST_DATA_LEAD: assert property ($rose(o_write_n) |-> o_mem_data == $past(o_mem_data, 3))
    else $error("write data moved");
  AST_RD_STROBE: assert property (!o_gate_n |-> o_write_n) else $error("strobe in read");
  AST_BUS_OFF: assert property (!o_gate_n |-> o_mem_data_oe_n) else $error("bus clash");
  AST_RD_WAIT: assert property ($fell(o_gate_n) |-> (!o_gate_n && !o_done)[*7] ##1 o_done)
    else $error("read sampled early");
  AST_WR_DONE: assert property ($rose(o_write_n) |-> o_done && o_chip_select_n)
    else $error("write end bad");
  AST_TURN: assert property (o_done |=> !o_ready ##1 !o_ready ##1 o_ready)
    else $error("no turnaround");
  AST_BYTE_STEADY: assert property (o_chip_select_n && $past(o_chip_select_n)
    |-> $stable({o_upper_byte_sel_n, o_lower_byte_sel_n})) else $error("byte select moved");
endmodule : asc_ctrl_asserts

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for asc_ctrl against a memory model
// Assumes: 100 MHz clock, reset held 8 cycles
// Notes:   reads compare only the lanes that were selected
`timescale 1ns/1ps
module tb_top;
  import asc_pkg::*;
  logic              i_core_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_req = 1'b0;
  logic              i_req_write = 1'b0;
  logic [ADDR_W-1:0] i_req_addr = '0;
  logic [DATA_W-1:0] i_req_wdata = '0;
  logic [1:0]        i_req_be = 2'h0;
  logic              o_ready, o_done, o_chip_select_n, o_chip_select_hi, o_write_n;
  logic              o_gate_n, o_upper_byte_sel_n, o_lower_byte_sel_n, o_mem_data_oe_n;
  logic [DATA_W-1:0] o_rdata, o_mem_data, i_mem_data, d;
  logic [ADDR_W-1:0] o_mem_addr, a;
  logic [DATA_W-1:0] sh [logic [ADDR_W-1:0]];
  logic [31:0]       q [$];
  logic [31:0]       last_rd = 32'hffff_0000;
  int                num_errors = 0, cmp_count = 0, seed = 83, i;
  always #5 i_core_clk = ~i_core_clk;
  asc_ctrl i_asc_ctrl (.i_core_clk, .i_rst, .i_req, .i_req_write, .i_req_addr, .i_req_wdata,
    .i_req_be, .o_ready, .o_done, .o_rdata, .o_mem_addr, .o_chip_select_n, .o_chip_select_hi,
    .o_write_n, .o_gate_n, .o_upper_byte_sel_n, .o_lower_byte_sel_n, .i_mem_data, .o_mem_data,
    .o_mem_data_oe_n);
  asc_mem_model i_asc_mem_model (.i_addr(o_mem_addr), .i_cs_n(o_chip_select_n),
    .i_cs_hi(o_chip_select_hi), .i_we_n(o_write_n), .i_oe_n(o_gate_n),
    .i_ub_n(o_upper_byte_sel_n), .i_lb_n(o_lower_byte_sel_n), .i_data(o_mem_data),
    .o_data(i_mem_data));
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // masked compare: upper half of e is the lane mask
  task automatic check(input string n, input logic [31:0] e, input logic [15:0] g);
    cmp_count++;
    if ((g & e[31:16]) !== (e[15:0] & e[31:16]))
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e[15:0], g);
    end
  endtask : check
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [1:0] b);
    logic [15:0] m;
    int          k;
    m = {{8{b[1]}}, {8{b[0]}}};
    for (k = 0; k < 30 && o_ready !== 1'b1; k++) step(1);
    if (k == 30)
    begin
      num_errors++;
      end_of_test();
    end
    {i_req, i_req_write, i_req_addr, i_req_wdata, i_req_be} = {1'b1, w, a, d, b};
    // a write must leave the last read word standing in o_rdata
    if (b != 2'h0 && !w) last_rd = {m, sh[a]};
    if (b != 2'h0) q.push_back(last_rd);
    if (w) sh[a] = (d & m) | (sh[a] & ~m);
    step(1);
    i_req = 1'b0;
    for (k = 0; k < 30 && o_done !== 1'b1; k++) step(1);
    check("o_done", {16'h0001, 15'h0, b != 2'h0}, {15'h0, k < 30});
    if (k == 30 && b != 2'h0) end_of_test();
  endtask : op
  // o_done and o_rdata launch on one edge; look half a cycle later while both stand
  always @(negedge i_core_clk)
    if (o_done === 1'b1)
      check("o_rdata", q.pop_front(), o_rdata);
  initial
  begin
    step(8);
    i_rst = 1'b0;
    for (i = 0; i < 12; i++)
    begin
      a = ADDR_W'($random(seed));
      d = DATA_W'($random(seed));
      op(1'b1, a, d, 2'h3);
      op(1'b1, a, ~d, 2'(i % 3 + 1));
      op(1'b1, a, d, 2'h0);
      op(1'b0, a, 16'h0000, 2'h3);
      op(1'b0, a, 16'h0000, 2'(i % 3 + 1));
    end
    end_of_test();
  end
endmodule : tb_top
bind asc_ctrl asc_ctrl_asserts i_asc_ctrl_asserts (.i_core_clk, .i_rst, .o_ready, .o_done,
  .o_mem_addr, .o_chip_select_n, .o_chip_select_hi, .o_write_n, .o_gate_n,
  .o_upper_byte_sel_n, .o_lower_byte_sel_n, .o_mem_data, .o_mem_data_oe_n);
